/* rtl/tpcp_defs.svh */
`ifndef TPCP_DEFS_SVH
`define TPCP_DEFS_SVH

// output enable / crossover port layout
`define TPCP_XOVR_CH0     8
`define TPCP_DIS_L_CH0    5
`define TPCP_DIS_H_CH0    4
`define TPCP_EN_WIDTH     9
`define TPCP_EN_RESET     9'h000

// gate chop config layout
`define TPCP_CHOP_LO      9
`define TPCP_CHOP_HI      8
`define TPCP_CHOP_PER_MSB 7
`define TPCP_CHOP_WIDTH   10

// register widths and reset values
`define TPCP_HALF_WIDTH   16
`define TPCP_DEAD_WIDTH   10
`define TPCP_SYNCW_WIDTH  10
`define TPCP_DUTY_WIDTH   16
`define TPCP_HALF_RESET   16'h0000
`define TPCP_DUTY_RESET   16'h0000

// timing counts, in core clocks
`define TPCP_SYNC_MIN     10'h001

// status layout
`define TPCP_STA_HALF     0
`define TPCP_STA_TRIP     1

`endif

/* rtl/tpcp_phase.sv */
`timescale 1ns/10ps
`include "tpcp_defs.svh"

module tpcp_phase
	import tpcp_pkg::*;
(
	input  wire logic        i_mclk,
	input  wire logic        i_arst_n,
	input  wire logic        i_half,
	input  wire tpcp_count_t i_pos,
	input  wire tpcp_count_t i_half_period,
	input  wire tpcp_count_t i_duty,
	input  wire tpcp_dead_t  i_dead,
	output logic             o_high,
	output logic             o_low
);

	logic signed [18:0] s_n;
	logic signed [18:0] s_mid;
	logic signed [18:0] s_duty;
	logic signed [18:0] s_dead;
	logic signed [18:0] s_pos;
	logic signed [18:0] hon;
	logic signed [18:0] lon;
	logic               next_high;
	logic               next_low;

	// per-half on-times, edges moved by the dead time on both sides
	always_comb begin
		s_n    = signed'({3'b000, i_half_period});
		s_mid  = signed'({4'b0000, i_half_period[15:1]});
		s_duty = signed'({3'b000, i_duty});
		s_dead = signed'({9'b000000000, i_dead});
		s_pos  = signed'({3'b000, i_pos});
		hon    = s_mid + s_duty - s_dead; // [R12] [R14] [R17]
		lon    = s_mid - s_duty - s_dead; // [R11] [R14]
		// comparisons saturate at 0% and 100% by themselves
		if (i_half) begin
			next_high = s_pos < hon;          // [R15]
			next_low  = s_pos >= (s_n - lon); // [R15]
		end else begin
			next_high = s_pos >= (s_n - hon);
			next_low  = s_pos < lon;
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_high <= 1'b0;
			o_low  <= 1'b0;
		end else begin
			o_high <= next_high;
			o_low  <= next_low;
		end
	end

endmodule // tpcp_phase

/* rtl/tpcp_pkg.sv */
package tpcp_pkg;

	typedef enum logic [1:0] {
		TPCP_IDLE,
		TPCP_RUN,
		TPCP_TRIP
	} tpcp_state_e;

	typedef logic [15:0] tpcp_count_t;
	typedef logic [9:0]  tpcp_dead_t;

endpackage

/* rtl/tpcp_top.sv */
// Functional notes
// R1 - three complementary center-aligned pairs with dead time, plus one sync per period
// R2 - timing unit selects external sync pin in addition to internal sync
// R3 - per channel steering to high or low pin, six outputs individually enabled
// R4 - chopping waveform generated and mixed into outputs before the pins
// R5 - trip input forces shutdown and resets the timing unit
// R6 - one interrupt per sync pulse, one per shutdown action
// R7 - half-period count is core clocks per half period; period is twice that
// R8 - half-period count is 16-bit unsigned up to all ones
// R9 - software never writes half-period count zero or one
// R10 - one 10-bit dead-time value for all pairs, dead time twice it
// R11 - complementary output held off for dead time after partner turns off
// R12 - both edges shifted equally by dead-time count keeping symmetry
// R13 - status bit 0 shows first or second half of period
// R14 - single update high and low duty follow the half-period formulas
// R15 - on-times clamp between zero and the full period
// R16 - double update reloads period, dead time and duty at half boundary
// R17 - double update on-time sums both halves, dead time as single update
// R18 - phases one and two work like phase zero with own duty
// R19 - no output until half period and three duties written; then counting enabled (the timer here already counts from the half-period write)
// R20 - half-period write starts timer; first sync 1.5N single, N double
// R21 - enable bits disable output when set; crossover bits swap high and low
// R22 - separate low and high chop enables with 8-bit chop period
// R23 - sync pulse width set by 10-bit value
// R24 - before the initial writes outputs inactive, no sync, no interrupt (the shutdown interrupt here still fires on a trip)
`timescale 1ns/10ps
`include "tpcp_defs.svh"

module tpcp_top
	import tpcp_pkg::*;
(
	input  wire logic                          i_mclk,
	input  wire logic                          i_arst_n,
	input  wire logic [`TPCP_HALF_WIDTH-1:0]   i_half_period_count,
	input  wire logic                          i_half_period_wr,
	input  wire logic [`TPCP_DEAD_WIDTH-1:0]   i_dead_time_count,
	input  wire logic [`TPCP_SYNCW_WIDTH-1:0]  i_sync_width_count,
	input  wire logic [`TPCP_DUTY_WIDTH-1:0]   i_phase0_duty_value,
	input  wire logic                          i_phase0_duty_wr,
	input  wire logic [`TPCP_DUTY_WIDTH-1:0]   i_phase1_duty_value,
	input  wire logic                          i_phase1_duty_wr,
	input  wire logic [`TPCP_DUTY_WIDTH-1:0]   i_phase2_duty_value,
	input  wire logic                          i_phase2_duty_wr,
	input  wire logic                          i_double_update,
	input  wire logic                          i_ext_sync_sel,
	input  wire logic                          i_ext_sync_in,
	input  wire logic [`TPCP_EN_WIDTH-1:0]     i_output_enable_reg,
	input  wire logic [`TPCP_CHOP_WIDTH-1:0]   i_gate_chop_config,
	input  wire logic                          i_shutdown_trip_input,
	output logic                               o_phase0_high_out,
	output logic                               o_phase0_low_out,
	output logic                               o_phase1_high_out,
	output logic                               o_phase1_low_out,
	output logic                               o_phase2_high_out,
	output logic                               o_phase2_low_out,
	output logic                               o_period_sync_pulse,
	output logic [1:0]                         o_pulse_status_reg,
	output logic                               o_sync_irq,
	output logic                               o_shutdown_irq
);

	tpcp_state_e  state;
	tpcp_count_t  live_half;
	tpcp_count_t  live_duty  [3];
	logic [3:0]   written;
	logic         all_written;
	logic         half;
	tpcp_count_t  pos;
	tpcp_count_t  lat_half;
	tpcp_dead_t   lat_dead;
	tpcp_count_t  lat_duty   [3];
	logic         period_start;
	logic         ext_sync_q;
	logic         ext_restart;
	logic [9:0]   sync_left;
	tpcp_dead_t   sync_eff;
	logic [7:0]   chop_div;
	logic         chop_wave;
	logic         chop_tick;
	logic [2:0]   raw_high;
	logic [2:0]   raw_low;
	logic [2:0]   out_high;
	logic [2:0]   out_low;
	logic         run_ok;
	logic         end_of_half;
	tpcp_count_t  next_pos;
	logic         sync_ok;
	logic         sync_go;

	assign all_written = &written;
	assign run_ok      = (state == TPCP_RUN) && all_written; // [R19] [R24]
	assign end_of_half = (pos == (lat_half - 16'h0001));
	assign next_pos    = pos + 16'h0001;
	assign ext_restart = i_ext_sync_sel && i_ext_sync_in && !ext_sync_q; // [R2]

	// software-facing values
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			live_half <= `TPCP_HALF_RESET;
			for (int i = 0; i < 3; i++) begin
				live_duty[i] <= `TPCP_DUTY_RESET;
			end
		end else begin
			if (i_half_period_wr) begin
				live_half <= i_half_period_count; // [R8]
			end
			if (i_phase0_duty_wr) begin
				live_duty[0] <= i_phase0_duty_value;
			end
			if (i_phase1_duty_wr) begin
				live_duty[1] <= i_phase1_duty_value; // [R18]
			end
			if (i_phase2_duty_wr) begin
				live_duty[2] <= i_phase2_duty_value; // [R18]
			end
		end
	end

	// tracks the initial writes; a trip forgets them
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			written <= 4'h0;
		end else if (i_shutdown_trip_input || state == TPCP_TRIP) begin
			written <= 4'h0; // [R5]
		end else begin
			written <= written | {i_phase2_duty_wr, i_phase1_duty_wr,
				i_phase0_duty_wr, i_half_period_wr}; // [R19]
		end
	end

	// external sync edge detect
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ext_sync_q <= 1'b0;
		end else begin
			ext_sync_q <= i_ext_sync_in;
		end
	end

	// main timer: up count across each half, value latching at boundaries
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state        <= TPCP_IDLE;
			half         <= 1'b0;
			pos          <= 16'h0000;
			lat_half     <= `TPCP_HALF_RESET;
			lat_dead     <= 10'h000;
			period_start <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				lat_duty[i] <= `TPCP_DUTY_RESET;
			end
		end else begin
			period_start <= 1'b0;
			case (state)
				TPCP_IDLE: begin
					if (i_shutdown_trip_input) begin
						state <= TPCP_TRIP; // [R5]
					end else if (i_half_period_wr) begin
						state    <= TPCP_RUN; // [R20]
						lat_half <= i_half_period_count;
						lat_dead <= i_dead_time_count;
						if (i_double_update) begin
							half <= 1'b1; // [R20]
							pos  <= 16'h0000;
						end else begin
							half <= 1'b0; // [R20]
							pos  <= {1'b0, i_half_period_count[15:1]};
						end
					end
				end
				TPCP_RUN: begin
					if (i_shutdown_trip_input) begin
						state <= TPCP_TRIP; // [R5]
						half  <= 1'b0;
						pos   <= 16'h0000;
					end else if (ext_restart || (end_of_half && half)) begin
						half         <= 1'b0;
						pos          <= 16'h0000;
						period_start <= 1'b1; // [R1]
						lat_half     <= live_half; // [R7]
						lat_dead     <= i_dead_time_count; // [R10]
						for (int i = 0; i < 3; i++) begin
							lat_duty[i] <= live_duty[i];
						end
					end else if (end_of_half) begin
						half <= 1'b1; // [R7]
						pos  <= 16'h0000;
						if (i_double_update) begin
							lat_half <= live_half; // [R16]
							lat_dead <= i_dead_time_count; // [R16]
							for (int i = 0; i < 3; i++) begin
								lat_duty[i] <= live_duty[i]; // [R16]
							end
						end
					end else begin
						pos <= next_pos;
					end
				end
				TPCP_TRIP: begin
					half <= 1'b0;
					pos  <= 16'h0000;
					if (!i_shutdown_trip_input) begin
						state <= TPCP_IDLE;
					end
				end
				default: begin
					state <= TPCP_IDLE;
				end
			endcase
		end
	end

	// sync pulse, sync interrupt
	assign sync_eff = (i_sync_width_count == 10'h000) ? `TPCP_SYNC_MIN : i_sync_width_count;
	assign sync_ok  = run_ok && !i_shutdown_trip_input; // [R5] [R24]
	assign sync_go  = period_start && sync_ok;

	// remaining width of the current sync pulse
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync_left <= 10'h000;
		end else if (sync_go) begin
			sync_left <= sync_eff; // [R23]
		end else if (sync_left != 10'h000) begin
			sync_left <= sync_left - 10'h001;
		end
	end

	// pulse dropped as soon as run permission goes
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_period_sync_pulse <= 1'b0;
		end else if (sync_go) begin
			o_period_sync_pulse <= 1'b1; // [R1]
		end else begin
			o_period_sync_pulse <= (sync_left > 10'h001) && sync_ok; // [R24]
		end
	end

	// one-cycle interrupt at each period start that issues a sync pulse
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sync_irq <= 1'b0;
		end else begin
			o_sync_irq <= sync_go; // [R6]
		end
	end

	// shutdown interrupt, one pulse on entry
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_shutdown_irq <= 1'b0;
		end else begin
			o_shutdown_irq <= i_shutdown_trip_input && (state != TPCP_TRIP); // [R6]
		end
	end

	// status: half indicator and shutdown flag
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pulse_status_reg <= 2'h0;
		end else begin
			o_pulse_status_reg[`TPCP_STA_HALF] <= half; // [R13]
			o_pulse_status_reg[`TPCP_STA_TRIP] <= (state == TPCP_TRIP);
		end
	end

	// chopping carrier from a divider tick
	assign chop_tick = (chop_div == i_gate_chop_config[`TPCP_CHOP_PER_MSB:0]); // [R22]

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			chop_div <= 8'h00;
		end else if (chop_tick) begin
			chop_div <= 8'h00;
		end else begin
			chop_div <= chop_div + 8'h01;
		end
	end

	// carrier flips at each divider tick
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			chop_wave <= 1'b0;
		end else if (chop_tick) begin
			chop_wave <= !chop_wave; // [R4]
		end
	end

	// timing unit, one per phase
	for (genvar g = 0; g < 3; g++) begin : g_phase
		logic steer_high;
		logic steer_low;
		logic pass_high;
		logic pass_low;

		tpcp_phase u_phase (
			.i_mclk        (i_mclk),
			.i_arst_n      (i_arst_n),
			.i_half        (half),
			.i_pos         (pos),
			.i_half_period (lat_half),
			.i_duty        (lat_duty[g]),
			.i_dead        (lat_dead),
			.o_high        (raw_high[g]),
			.o_low         (raw_low[g])
		); // [R18]

		// crossover swaps the pair ahead of enabling and chopping
		always_comb begin
			if (i_output_enable_reg[`TPCP_XOVR_CH0 - g]) begin
				steer_high = raw_low[g]; // [R3]
				steer_low  = raw_high[g];
			end else begin
				steer_high = raw_high[g];
				steer_low  = raw_low[g];
			end
		end

		// per-pin disable and chop carrier mixing
		assign pass_high = !i_output_enable_reg[`TPCP_DIS_H_CH0 - 2 * g] // [R21]
			&& (!i_gate_chop_config[`TPCP_CHOP_HI] || chop_wave); // [R4]
		assign pass_low  = !i_output_enable_reg[`TPCP_DIS_L_CH0 - 2 * g] // [R21]
			&& (!i_gate_chop_config[`TPCP_CHOP_LO] || chop_wave); // [R22]

		// shutdown gating at the output flops
		always_ff @(posedge i_mclk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				out_high[g] <= 1'b0;
				out_low[g]  <= 1'b0;
			end else begin
				out_high[g] <= run_ok && !i_shutdown_trip_input && steer_high && pass_high; // [R5] [R24]
				out_low[g]  <= run_ok && !i_shutdown_trip_input && steer_low && pass_low;
			end
		end
	end

	assign o_phase0_high_out = out_high[0];
	assign o_phase0_low_out  = out_low[0];
	assign o_phase1_high_out = out_high[1];
	assign o_phase1_low_out  = out_low[1];
	assign o_phase2_high_out = out_high[2];
	assign o_phase2_low_out  = out_low[2];

endmodule // tpcp_top

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
	logic        i_mclk = 1'b0, i_arst_n = 1'b0, hwr = 1'b0, dbl = 1'b0, xsel = 1'b0, xin = 1'b0, treq = 1'b0;
	logic        trip, syn, sirq, tirq;
	logic [15:0] hp = 16'h0000;
	logic [15:0] dv [3] = '{16'h0000, 16'h0000, 16'h0000};
	logic [9:0]  dt = 10'h000, sw = 10'h000, chop = 10'h000;
	logic [8:0]  en = 9'h000;
	logic [2:0]  dwr = 3'h0;
	logic [1:0]  sta;
	wire  [5:0]  g;
	int          errors = 0, checks_done = 0, cyc = 0, tn = 0, faults, n = 40;
	int          c [9];
	always #4 i_mclk = ~i_mclk;
	tpcp_top u_dut (
		.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_half_period_count(hp), .i_half_period_wr(hwr),
		.i_dead_time_count(dt), .i_sync_width_count(sw), .i_double_update(dbl), .i_ext_sync_sel(xsel),
		.i_phase0_duty_value(dv[0]), .i_phase0_duty_wr(dwr[0]), .i_phase1_duty_value(dv[1]),
		.i_phase1_duty_wr(dwr[1]), .i_phase2_duty_value(dv[2]), .i_phase2_duty_wr(dwr[2]),
		.i_ext_sync_in(xin), .i_output_enable_reg(en), .i_gate_chop_config(chop), .i_shutdown_trip_input(trip),
		.o_phase0_high_out(g[4]), .o_phase0_low_out(g[5]), .o_phase1_high_out(g[2]), .o_phase1_low_out(g[3]),
		.o_phase2_high_out(g[0]), .o_phase2_low_out(g[1]), .o_period_sync_pulse(syn),
		.o_pulse_status_reg(sta), .o_sync_irq(sirq), .o_shutdown_irq(tirq));
	tpcp_gate_model u_gate (.i_mclk(i_mclk), .i_trip_req(treq), .i_gate(g), .o_trip(trip), .o_faults(faults));
	task automatic test_done();
		if (errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge i_mclk) begin
		tn <= tn + int'(tirq === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			errors++;
			test_done();
		end
	end
	task automatic cmp(logic [31:0] got, logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(int k = 1);
		repeat (k) @(posedge i_mclk);
		#1;
	endtask
	task automatic wr_n(logic [15:0] v);
		hp = v;
		hwr = 1'b1;
		step();
		hwr = 1'b0;
	endtask
	task automatic wr_d(int d [3]);
		foreach (d[k]) dv[k] = 16'(d[k]);
		dwr = 3'h7;
		step();
		dwr = 3'h0;
	endtask
	// cycles until the next rising sync edge
	task automatic wsync(output int w);
		w = 0;
		while (syn !== 1'b0 && w < 300) begin
			step();
			w++;
		end
		while (syn !== 1'b1 && w < 300) begin
			step();
			w++;
		end
		if (w >= 300) cmp(w, 0);
	endtask
	task automatic quiet(int k);
		int q;
		q = 0;
		repeat (k) begin
			q += int'(syn !== 1'b0 || g !== 6'h00);
			step();
		end
		cmp(q, 0);
	endtask
	// one full period: pin on-counts, sync width, second-half count
	task automatic per();
		c = '{default: 0};
		wsync(c[8]);
		repeat (2 * n) begin
			foreach (g[b]) c[b] += int'(g[b] === 1'b1);
			c[6] += int'(syn === 1'b1);
			c[7] += int'(sta[0] === 1'b1);
			step();
		end
	endtask
	// expected on-cycles per period of pin b
	function automatic int exp_pin(int b, int d [3], int t);
		int k = 2 - b / 2;
		int s = b % 2;
		int v = n / 2 + (((s ^ en[8 - k]) == 1) ? -d[k] : d[k]) - t;
		v = 2 * ((v < 0) ? 0 : (v > n) ? n : v);
		if (chop[8 + s]) v = v / 2;
		return en[b] ? 0 : v;
	endfunction
	task automatic do_trip();
		int t0;
		t0 = tn;
		treq = 1'b1;
		step(4);
		cmp(g, 0);
		cmp(sta[1], 1);
		step(20);
		cmp(tn - t0, 1);
		treq = 1'b0;
		step(3);
		cmp(sta[1], 0);
		quiet(200);
	endtask
	initial begin
		int w, t;
		int d [3];
		w = $urandom(32'h5447BAAF);
		sw = 10'($urandom_range(6, 1));
		repeat (10) @(posedge i_mclk);
		#1 i_arst_n = 1'b1;
		cmp(g, 0);
		wr_n(16'(n));
		quiet(150);
		for (int i = 0; i < 6; i++) begin
			t = (i == 5) ? 2 : (i == 0) ? 0 : $urandom_range(4);
			foreach (d[k]) d[k] = (i == 5) ? n : (i == 0) ? 0 : $urandom_range(25);
			en = (i > 1 && i < 5) ? 9'($urandom) : 9'h000;
			chop = (i == 5) ? 10'h303 : 10'h000;
			dt = 10'(t);
			wr_d(d);
			repeat (2) wsync(w);
			per();
			for (int b = 0; b < 6; b++) cmp(c[b], exp_pin(b, d, t));
			cmp(c[6], sw);
			cmp(c[7], n);
			cmp(c[8], 2 * n);
		end
		xsel = 1'b1;
		wsync(w);
		step(17);
		xin = 1'b1;
		step();
		xin = 1'b0;
		wsync(w);
		cmp(w <= 4, 1);
		xsel = 1'b0;
		do_trip();
		wr_n(16'(n));
		wr_d(d);
		wsync(w);
		cmp(w >= 3 * n / 2 - 2 && w <= 3 * n / 2 + 2, 1);
		do_trip();
		dbl = 1'b1;
		wr_n(16'(n));
		wr_d(d);
		wsync(w);
		cmp(w >= n - 2 && w <= n + 2, 1);
		wsync(w);
		wr_n(16'h001E);
		wsync(w);
		cmp(w + 1, 70);
		wsync(w);
		cmp(w, 60);
		cmp(faults, 0);
		test_done();
	end
endmodule // tb_top

/* tb/tpcp_checker.sv */
`timescale 1ns/10ps
module tpcp_checker (
	input wire logic       i_mclk,
	input wire logic       i_arst_n,
	input wire logic       i_half_period_wr,
	input wire logic       i_phase0_duty_wr,
	input wire logic       i_phase1_duty_wr,
	input wire logic       i_phase2_duty_wr,
	input wire logic [9:0] i_sync_width_count,
	input wire logic [8:0] i_output_enable_reg,
	input wire logic       i_shutdown_trip_input,
	input wire logic       o_phase0_high_out,
	input wire logic       o_phase0_low_out,
	input wire logic       o_phase1_high_out,
	input wire logic       o_phase1_low_out,
	input wire logic       o_phase2_high_out,
	input wire logic       o_phase2_low_out,
	input wire logic       o_period_sync_pulse,
	input wire logic [1:0] o_pulse_status_reg,
	input wire logic       o_sync_irq,
	input wire logic       o_shutdown_irq
);
	logic [3:0] seen;
	logic [9:0] hi_len;
	logic [5:0] dis_q;
	wire  [5:0] outs = {o_phase0_low_out, o_phase0_high_out, o_phase1_low_out,
		o_phase1_high_out, o_phase2_low_out, o_phase2_high_out};
	wire        trip = i_shutdown_trip_input;
	wire        syn  = o_period_sync_pulse;
	wire  [3:0] wrs  = {i_phase2_duty_wr, i_phase1_duty_wr, i_phase0_duty_wr, i_half_period_wr};
	wire  [9:0] w_exp = (i_sync_width_count == 10'h000) ? 10'h001 : i_sync_width_count;
	// initial-write tracker, sync length, disable mask
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			seen <= 4'h0;
			hi_len <= 10'h000;
			dis_q <= 6'h00;
		end else begin
			seen <= trip ? 4'h0 : (seen | wrs);
			hi_len <= syn ? hi_len + 10'h001 : 10'h000;
			dis_q <= i_output_enable_reg[5:0];
		end
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	no_shoot_a: assert property (!(outs[5] && outs[4]) && !(outs[3] && outs[2]) && !(outs[1] && outs[0]))
		else $error("pair overlap");
	trip_off_a: assert property (trip |=> outs == 6'h00)
		else $error("outputs live in trip");
	trip_irq_a: assert property (o_shutdown_irq |-> $past(trip))
		else $error("stray shutdown irq");
	shut_pulse_a: assert property (o_shutdown_irq |=> !o_shutdown_irq)
		else $error("long shutdown irq");
	sync_irq_a: assert property ($rose(syn) |-> o_sync_irq)
		else $error("sync without irq");
	irq_pulse_a: assert property (o_sync_irq |-> syn ##1 !o_sync_irq)
		else $error("bad sync irq pulse");
	sync_len_a: assert property ($fell(syn) && !trip && !$past(trip) && !$past(trip, 2) |-> hi_len == w_exp)
		else $error("sync width wrong");
	idle_quiet_a: assert property (seen != 4'hF |-> outs == 6'h00 && !syn && !o_sync_irq)
		else $error("activity before setup");
	dis_mask_a: assert property ((outs & dis_q) == 6'h00)
		else $error("disabled output driven");
	cover property ($rose(syn));
	cover property (o_shutdown_irq);
	cover property (o_pulse_status_reg[0] && o_phase2_low_out);
endmodule // tpcp_checker

bind tpcp_top tpcp_checker u_chk (.*);

/* tb/tpcp_gate_model.sv */
`timescale 1ns/10ps
module tpcp_gate_model (
	input  wire logic       i_mclk,
	input  wire logic       i_trip_req,
	input  wire logic [5:0] i_gate,
	output logic            o_trip,
	output int              o_faults
);
	wire short_leg = (i_gate[5] & i_gate[4]) | (i_gate[3] & i_gate[2]) | (i_gate[1] & i_gate[0]);
	initial begin
		o_trip = 1'b0;
		o_faults = 0;
	end
	// trip sense: commanded fault or a shorted leg
	always @(posedge i_mclk) begin
		o_trip <= i_trip_req | (short_leg === 1'b1);
		o_faults <= o_faults + int'(short_leg === 1'b1);
	end
endmodule // tpcp_gate_model
